/* common/t8oc_defines.vh */
// Register offsets, field positions, encodings and reset values of the compare unit
`ifndef T8OC_DEFINES_VH
`define T8OC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define T8OC_ADDR_CTRL 8'h00
`define T8OC_ADDR_COUNT 8'h04
`define T8OC_ADDR_COMPARE 8'h08
`define T8OC_ADDR_FLAGS 8'h0C
`define T8OC_ADDR_IRQEN 8'h10
`define T8OC_ADDR_STATUS 8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define T8OC_CTRL_WAVE_LSB 0
`define T8OC_CTRL_WAVE_MSB 1
`define T8OC_CTRL_ACT_LSB 2
`define T8OC_CTRL_ACT_MSB 3
`define T8OC_CTRL_CLK_LSB 4
`define T8OC_CTRL_CLK_MSB 6
`define T8OC_CTRL_FORCE_BIT 7

// ----------------------------------------------------------------
// Flag, enable and status bits
// ----------------------------------------------------------------
`define T8OC_OVF_BIT 0
`define T8OC_MATCH_BIT 1
`define T8OC_STAT_OUT_BIT 0
`define T8OC_STAT_DIR_BIT 1
`define T8OC_STAT_BLOCK_BIT 2

// ----------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------
`define T8OC_WAVE_NORMAL 2'h0
`define T8OC_WAVE_PHASE 2'h1
`define T8OC_WAVE_CLRMATCH 2'h2
`define T8OC_WAVE_FAST 2'h3
`define T8OC_ACT_NONE 2'h0
`define T8OC_ACT_TOGGLE 2'h1
`define T8OC_ACT_CLEAR 2'h2
`define T8OC_ACT_SET 2'h3
`define T8OC_CLK_STOP 3'h0
`define T8OC_CLK_DIRECT 3'h1

// ----------------------------------------------------------------
// Counter limits and reset values
// ----------------------------------------------------------------
`define T8OC_BOTTOM 8'h00
`define T8OC_MAX 8'hFF
`define T8OC_RST_BYTE 8'h00

`endif

/* rtl/t8oc_top.v */
// Output compare unit of an 8-bit timer/counter with APB register access
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "t8oc_defines.vh"

module t8oc_top
(
  input wire ref_clk_i,
  input wire arst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire prescale_tick_i,
  input wire global_irq_en_i,
  input wire compare_irq_ack_i,
  input wire overflow_irq_ack_i,
  input wire port_data_i,
  input wire port_dir_i,
  output wire compare_irq_o,
  output wire overflow_irq_o,
  output wire pin_o,
  output wire pin_oe_o
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [1:0] wave_mode_q;
  reg [1:0] out_action_q;
  reg [2:0] clk_sel_q;
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg [7:0] cmp_active_q;
  reg [7:0] cmp_active_d;
  reg [7:0] cmp_buffer_q;
  reg [7:0] cmp_buffer_d;
  reg match_flag_q;
  reg match_flag_d;
  reg ovf_flag_q;
  reg ovf_flag_d;
  reg match_irq_en_q;
  reg ovf_irq_en_q;
  reg block_q;
  reg block_d;
  reg down_q;
  reg down_d;
  reg cmp_out_q;
  reg cmp_out_d;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function is_pwm;
    input [1:0] mode;
    begin
      is_pwm = (mode == `T8OC_WAVE_PHASE) || (mode == `T8OC_WAVE_FAST);
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `T8OC_ADDR_CTRL) || (addr == `T8OC_ADDR_COUNT) ||
        (addr == `T8OC_ADDR_COMPARE) || (addr == `T8OC_ADDR_FLAGS) ||
        (addr == `T8OC_ADDR_IRQEN) || (addr == `T8OC_ADDR_STATUS);
    end
  endfunction

  // Output state after a match with a given action; zero keeps it
  function act_apply;
    input [1:0] act;
    input cur;
    begin
      case (act)
        `T8OC_ACT_TOGGLE: act_apply = ~cur;
        `T8OC_ACT_CLEAR: act_apply = 1'b0;
        `T8OC_ACT_SET: act_apply = 1'b1;
        default: act_apply = cur;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access_w = psel_i & penable_i;
  wire wr_en = access_w & pwrite_i & is_mapped(paddr_i);
  wire wr_ctrl = wr_en & (paddr_i == `T8OC_ADDR_CTRL);
  wire wr_count = wr_en & (paddr_i == `T8OC_ADDR_COUNT);
  wire wr_cmp = wr_en & (paddr_i == `T8OC_ADDR_COMPARE);
  wire wr_flags = wr_en & (paddr_i == `T8OC_ADDR_FLAGS);
  wire wr_irqen = wr_en & (paddr_i == `T8OC_ADDR_IRQEN);

  // Zero wait states keeps the core simple; unmapped access answers an error
  assign pready_o = 1'b1;
  assign pslverr_o = access_w & ~is_mapped(paddr_i);

  // ----------------------------------------------------------------
  // Timer tick and compare
  // ----------------------------------------------------------------
  wire pwm_w = is_pwm(wave_mode_q);
  // Stopped source yields no tick at all
  wire tick = (clk_sel_q == `T8OC_CLK_STOP) ? 1'b0 :
    (clk_sel_q == `T8OC_CLK_DIRECT) ? 1'b1 : prescale_tick_i;
  wire equal_w = (count_q == cmp_active_q);
  // A blocked tick sees no match at all
  wire match_tick = tick & equal_w & ~block_q;
  wire at_max = (count_q == `T8OC_MAX);
  wire at_bottom = (count_q == `T8OC_BOTTOM);
  wire force_w = wr_ctrl & pwdata_i[`T8OC_CTRL_FORCE_BIT] & ~pwm_w;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always @*
  begin
    count_d = count_q;
    down_d = down_q;
    ovf_flag_d = ovf_flag_q;
    // Service acknowledge and write-one clear first, so a set in the same cycle wins
    if (overflow_irq_ack_i | (wr_flags & pwdata_i[`T8OC_OVF_BIT]))
      ovf_flag_d = 1'b0;
    if (tick)
    begin
      case (wave_mode_q)
        `T8OC_WAVE_CLRMATCH:
        begin
          if (equal_w & ~block_q)
          begin
            count_d = `T8OC_BOTTOM;
          end
          else
          begin
            // A top written below the count waits for the wrap
            count_d = count_q + 8'h01;
            if (at_max)
            begin
              ovf_flag_d = 1'b1;
            end
          end
        end
        `T8OC_WAVE_PHASE:
        begin
          // Dual slope, turning at both ends
          if (down_q)
          begin
            if (at_bottom)
            begin
              down_d = 1'b0;
              count_d = count_q + 8'h01;
            end
            else
            begin
              count_d = count_q - 8'h01;
              if (count_q == 8'h01)
              begin
                ovf_flag_d = 1'b1;
              end
            end
          end
          else if (at_max)
          begin
            down_d = 1'b1;
            count_d = count_q - 8'h01;
          end
          else
          begin
            count_d = count_q + 8'h01;
          end
        end
        default:
        begin
          // Normal and fast PWM count up and wrap
          count_d = count_q + 8'h01;
          if (at_max)
          begin
            ovf_flag_d = 1'b1;
          end
        end
      endcase
    end
    if (~is_pwm(wave_mode_q) | (wave_mode_q == `T8OC_WAVE_FAST))
    begin
      down_d = 1'b0;
    end
    if (wr_count)
      count_d = pwdata_i[7:0];
  end

  // ----------------------------------------------------------------
  // Match flag and blocking
  // ----------------------------------------------------------------
  always @*
  begin
    match_flag_d = match_flag_q;
    if (compare_irq_ack_i | (wr_flags & pwdata_i[`T8OC_MATCH_BIT]))
      match_flag_d = 1'b0;
    if (match_tick)
      match_flag_d = 1'b1;
    block_d = block_q;
    if (tick)
      block_d = 1'b0;
    // Block holds until a tick has passed, even when stopped
    if (wr_count)
      block_d = 1'b1;
  end

  // ----------------------------------------------------------------
  // Compare register, buffered in PWM modes
  // ----------------------------------------------------------------
  always @*
  begin
    cmp_active_d = cmp_active_q;
    cmp_buffer_d = cmp_buffer_q;
    if (pwm_w)
    begin
      // Update at the turn of the count only, avoiding odd pulses
      if (tick & at_max & ~down_q)
      begin
        cmp_active_d = cmp_buffer_q;
      end
      if (wr_cmp)
      begin
        cmp_buffer_d = pwdata_i[7:0];
      end
    end
    else if (wr_cmp)
    begin
      cmp_active_d = pwdata_i[7:0];
      cmp_buffer_d = pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Waveform state
  // ----------------------------------------------------------------
  always @*
  begin
    cmp_out_d = cmp_out_q;
    case (wave_mode_q)
      `T8OC_WAVE_FAST:
      begin
        if (match_tick)
        begin
          cmp_out_d = act_apply(out_action_q, cmp_out_q);
        end
        else if (tick & at_max)
        begin
          if (out_action_q == `T8OC_ACT_CLEAR)
          begin
            cmp_out_d = 1'b1;
          end
          else if (out_action_q == `T8OC_ACT_SET)
          begin
            cmp_out_d = 1'b0;
          end
        end
      end
      `T8OC_WAVE_PHASE:
      begin
        if (match_tick & out_action_q[1])
        begin
          // Clear going up, set going down; action three inverts
          cmp_out_d = down_q ^ out_action_q[0];
        end
      end
      default:
      begin
        if (force_w)
        begin
          // Forced match touches only the output
          cmp_out_d = act_apply(pwdata_i[`T8OC_CTRL_ACT_MSB:`T8OC_CTRL_ACT_LSB], cmp_out_q);
        end
        else if (match_tick)
        begin
          cmp_out_d = act_apply(out_action_q, cmp_out_q);
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wave_mode_q <= `T8OC_WAVE_NORMAL;
      out_action_q <= `T8OC_ACT_NONE;
      clk_sel_q <= `T8OC_CLK_STOP;
      count_q <= `T8OC_RST_BYTE;
      cmp_active_q <= `T8OC_RST_BYTE;
      cmp_buffer_q <= `T8OC_RST_BYTE;
      match_flag_q <= 1'b0;
      ovf_flag_q <= 1'b0;
      match_irq_en_q <= 1'b0;
      ovf_irq_en_q <= 1'b0;
      block_q <= 1'b0;
      down_q <= 1'b0;
      cmp_out_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        wave_mode_q <= pwdata_i[`T8OC_CTRL_WAVE_MSB:`T8OC_CTRL_WAVE_LSB];
        out_action_q <= pwdata_i[`T8OC_CTRL_ACT_MSB:`T8OC_CTRL_ACT_LSB];
        clk_sel_q <= pwdata_i[`T8OC_CTRL_CLK_MSB:`T8OC_CTRL_CLK_LSB];
      end
      if (wr_irqen)
      begin
        match_irq_en_q <= pwdata_i[`T8OC_MATCH_BIT];
        ovf_irq_en_q <= pwdata_i[`T8OC_OVF_BIT];
      end
      count_q <= count_d;
      cmp_active_q <= cmp_active_d;
      cmp_buffer_q <= cmp_buffer_d;
      match_flag_q <= match_flag_d;
      ovf_flag_q <= ovf_flag_d;
      block_q <= block_d;
      down_q <= down_d;
      cmp_out_q <= cmp_out_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      prdata_o <= 32'h0000_0000;
    end
    else if (psel_i & ~penable_i & ~pwrite_i)
    begin
      case (paddr_i)
        `T8OC_ADDR_CTRL:
          prdata_o <= {25'h000_0000, clk_sel_q, out_action_q, wave_mode_q};
        `T8OC_ADDR_COUNT:
          prdata_o <= {24'h00_0000, count_q};
        `T8OC_ADDR_COMPARE:
          prdata_o <= {24'h00_0000, (pwm_w ? cmp_buffer_q : cmp_active_q)};
        `T8OC_ADDR_FLAGS:
          prdata_o <= {30'h0000_0000, match_flag_q, ovf_flag_q};
        `T8OC_ADDR_IRQEN:
          prdata_o <= {30'h0000_0000, match_irq_en_q, ovf_irq_en_q};
        `T8OC_ADDR_STATUS:
          prdata_o <= {29'h0000_0000, block_q, down_q, cmp_out_q};
        default:
          prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests and pin override
  // ----------------------------------------------------------------
  assign compare_irq_o = match_flag_q & match_irq_en_q & global_irq_en_i;
  assign overflow_irq_o = ovf_flag_q & ovf_irq_en_q & global_irq_en_i;
  // Override holds in every mode; direction stays with the port
  assign pin_o = (out_action_q != `T8OC_ACT_NONE) ? cmp_out_q : port_data_i;
  assign pin_oe_o = port_dir_i;

endmodule // t8oc_top
`default_nettype wire

/* verification/t8oc_cpu_model.sv */
// Processor model: APB master transfers and interrupt service
`timescale 1ns/1ns
`default_nettype none
module t8oc_cpu_model
(
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic [1:0] irq_i,
  input wire logic svc_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [1:0] ack_o
);
  int hung = 0;
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
    ack_o = 2'b00;
  end
  // One-cycle acknowledge, so each service is a single clear event
  always @(posedge clk_i)
    ack_o <= svc_i ? irq_i & ~ack_o : 2'b00;
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!pready_i && n < 16);
    if (!pready_i)
      hung++;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // Released data lines must not keep the last word
    pwdata_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // t8oc_cpu_model
`default_nettype wire

/* verification/t8oc_monitor.sv */
// Concurrent checks on the compare unit ports
`timescale 1ns/1ns
`default_nettype none
`include "t8oc_defines.vh"
module t8oc_monitor
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic global_irq_en_i,
  input wire logic port_data_i,
  input wire logic port_dir_i,
  input wire logic compare_irq_o,
  input wire logic overflow_irq_o,
  input wire logic pin_o,
  input wire logic pin_oe_o
);
  // Mirror of control, so checks know action and clock select
  logic [7:0] ctrl_q;
  wire logic wr_acc = psel_i & penable_i & pwrite_i;
  wire logic ctl_wr = wr_acc & (paddr_i == `T8OC_ADDR_CTRL);
  wire logic stop = ctrl_q[6:4] == `T8OC_CLK_STOP;
  wire logic [1:0] act = ctrl_q[3:2];
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      ctrl_q <= 8'h00;
    else if (ctl_wr)
      ctrl_q <= pwdata_i[7:0];
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_pin_source: assert property (act == `T8OC_ACT_NONE |-> pin_o == port_data_i)
    else $error("pin not on port data");
  a_pin_dir: assert property (pin_oe_o == port_dir_i)
    else $error("pin enable not on direction");
  a_irq_gate: assert property (!global_irq_en_i |-> !compare_irq_o && !overflow_irq_o)
    else $error("irq without global enable");
  a_flag_w1c: assert property (wr_acc && paddr_i == `T8OC_ADDR_FLAGS && pwdata_i[1]
    && stop |=> !compare_irq_o)
    else $error("flag survived clear");
  a_stop_no_set: assert property (stop && !wr_acc && !compare_irq_o
    |=> !compare_irq_o || $rose(global_irq_en_i))
    else $error("flag set while stopped");
  a_force_toggle: assert property (ctl_wr && pwdata_i[7:0] == 8'h84
    && act == `T8OC_ACT_TOGGLE |=> pin_o != $past(pin_o))
    else $error("force did not toggle");
  a_force_no_flag: assert property (ctl_wr && pwdata_i[7] && pwdata_i[6:4] == 3'h0
    && stop && !compare_irq_o |=> !compare_irq_o)
    else $error("force set flag");
  a_pin_hold: assert property (stop && act != `T8OC_ACT_NONE && !wr_acc |=> $stable(pin_o))
    else $error("output moved without tick");
  c_force: cover property (ctl_wr && pwdata_i[7]);
  c_cmp_irq: cover property ($rose(compare_irq_o));
  c_ovf_irq: cover property ($rose(overflow_irq_o));
endmodule // t8oc_monitor
bind t8oc_top t8oc_monitor u_mon
(
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .global_irq_en_i(global_irq_en_i), .port_data_i(port_data_i), .port_dir_i(port_dir_i),
  .compare_irq_o(compare_irq_o), .overflow_irq_o(overflow_irq_o), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o)
);
`default_nettype wire

/* verification/t8oc_tb_top.sv */
// Self-checking bench for the timer compare unit
`timescale 1ns/1ns
`default_nettype none
`include "t8oc_defines.vh"
module t8oc_tb_top;
  localparam logic [7:0] ctl = `T8OC_ADDR_CTRL;
  localparam logic [7:0] cnt = `T8OC_ADDR_COUNT;
  localparam logic [7:0] cmp = `T8OC_ADDR_COMPARE;
  localparam logic [7:0] flg = `T8OC_ADDR_FLAGS;
  localparam logic [7:0] sts = `T8OC_ADDR_STATUS;
  logic clk, arst_n, psel, penable, pwrite, pt, ge, pd, pdir, svc;
  logic pready, pslverr, cirq, oirq, pin, pin_oe;
  logic [7:0] paddr;
  logic [7:0] c;
  logic [31:0] pwdata, prdata;
  logic [1:0] ack;
  logic [31:0] lfsr_q = 32'h4296_440e;
  logic [31:0] exp_q[$];
  logic [1:0] acts[4] = '{2'h1, 2'h1, 2'h2, 2'h3};
  logic st[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  int errors = 0;
  int n_tests = 0;
  t8oc_top u_dut
  (
    .ref_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .prescale_tick_i(pt), .global_irq_en_i(ge),
    .compare_irq_ack_i(ack[0]), .overflow_irq_ack_i(ack[1]), .port_data_i(pd),
    .port_dir_i(pdir), .compare_irq_o(cirq), .overflow_irq_o(oirq), .pin_o(pin),
    .pin_oe_o(pin_oe)
  );
  t8oc_cpu_model u_cpu
  (
    .clk_i(clk), .pready_i(pready), .irq_i({oirq, cirq}), .svc_i(svc), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .ack_o(ack)
  );
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    u_cpu.xfer(1'b0, a, 32'h0000_0000);
  endtask
  // Tick held high for n edges; never called back to back
  task automatic tk(input int n);
    pt <= 1'b1;
    repeat (n) @(posedge clk);
    pt <= 1'b0;
  endtask
  task automatic pchk(input logic e);
    @(negedge clk);
    check({31'h0, pin}, {31'h0, e});
    @(posedge clk);
  endtask
  task automatic done(input int k);
    $display("Test %0d done", k);
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk)
    if (psel && penable && !pwrite && pready)
    begin
      check(prdata, exp_q.pop_front());
      check({31'h0, pslverr}, {31'h0, paddr > sts});
    end
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #400000;
    errors++;
    finish_test;
  end
  initial
  begin
    int i;
    arst_n = 1'b0;
    {pt, ge, svc, pd, pdir} = 5'h00;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (i = 0; i < 28; i += 4)
      rd(8'(i), 8'h00);
    done(1);
    lfsr_q = nxt(lfsr_q);
    c = 8'h03 + 8'(lfsr_q % 200);
    pd <= lfsr_q[0];
    pdir <= lfsr_q[1];
    wr(ctl, 8'h26);
    wr(cmp, c);
    wr(cnt, c - 8'h02);
    tk(2);
    rd(cnt, c);
    rd(flg, 8'h00);
    tk(1);
    rd(cnt, 8'h00);
    rd(flg, 8'h02);
    rd(sts, 8'h01);
    wr(flg, 8'h02);
    rd(flg, 8'h00);
    wr(cnt, c);
    rd(sts, 8'h05);
    tk(1);
    rd(cnt, c + 8'h01);
    rd(flg, 8'h00);
    tk(255 - c);
    rd(cnt, 8'h00);
    rd(flg, 8'h01);
    wr(`T8OC_ADDR_IRQEN, 8'h03);
    ge <= 1'b1;
    svc <= 1'b1;
    repeat (4) @(posedge clk);
    rd(flg, 8'h00);
    svc <= 1'b0;
    done(2);
    wr(ctl, 8'h23);
    wr(cmp, c + 8'h01);
    rd(cmp, c + 8'h01);
    wr(cnt, c - 8'h01);
    tk(2);
    rd(flg, 8'h02);
    rd(sts, 8'h01);
    wr(ctl, 8'h01);
    rd(ctl, 8'h01);
    wr(ctl, 8'h00);
    rd(sts, 8'h01);
    pchk(pd);
    check({31'h0, pin_oe}, {31'h0, pdir});
    wr(flg, 8'h03);
    rd(flg, 8'h00);
    done(3);
    for (i = 0; i < 4; i++)
    begin
      wr(ctl, 8'h80 | {4'h0, acts[i], 2'h0});
      rd(sts, {7'h00, st[i]});
      pchk(st[i]);
    end
    rd(cnt, c + 8'h01);
    rd(flg, 8'h00);
    tk(3);
    rd(cnt, c + 8'h01);
    wr(cnt, 8'h5A);
    rd(cnt, 8'h5A);
    wr(ctl, 8'h20);
    wr(cmp, 8'h00);
    pt <= 1'b1;
    wr(cnt, 8'hFF);
    pt <= 1'b0;
    rd(cnt, 8'h00);
    rd(flg, 8'h01);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(sts, 8'h00);
    pchk(pd);
    check(32'(u_cpu.hung), 32'h0000_0000);
    done(4);
    finish_test;
  end
endmodule // t8oc_tb_top
`default_nettype wire
